/* File: common/pll_ctrl_pkg.sv */
// Purpose: shared constants and types for the pll reference switchover and phase step block
// Assumes: ahb-lite register slave, 32-bit words, one core clock
// Notes:   register map and most field positions live here; status bit packing and the phase word tap position sit in the design
package pll_ctrl_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ctrl_off       = 8'h00;
	localparam logic [7:0] status_off     = 8'h04;
	localparam logic [7:0] irq_status_off = 8'h08;
	localparam logic [7:0] irq_mask_off   = 8'h0C;
	localparam logic [7:0] phase0_off     = 8'h10;
	localparam logic [7:0] phase1_off     = 8'h14;

	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int          ctrl_auto_bit   = 0;
	localparam int          ctrl_swreq_bit  = 1;
	localparam logic [1:0]  ctrl_reset      = 2'h1;
	localparam int          irq_lost0_bit   = 0;
	localparam int          irq_lost1_bit   = 1;
	localparam int          irq_switch_bit  = 2;
	localparam int          irq_phase_bit   = 3;
	localparam int          irq_width       = 4;
	localparam logic [3:0]  irq_mask_reset  = 4'h0;
	localparam int          coarse_lsb      = 8;
	localparam logic [7:0]  coarse_reset    = 8'h01;

	// ---------------------------------------------------------------
	// timing and tap geometry
	// ---------------------------------------------------------------
	localparam int          cnt_width       = 16;
	localparam logic [15:0] period_init     = 16'h0100;
	localparam logic [15:0] cnt_max         = 16'hFFFF;
	localparam int          lost_periods    = 2;
	localparam int          tap_count       = 8;
	localparam int          tap_width       = 3;
	localparam logic [2:0]  tap_last        = 3'h7;
	localparam int          num_outputs     = 2;

	typedef enum logic [1:0] {
		sw_idle = 2'b00,
		sw_gate = 2'b01,
		sw_swap = 2'b10
	} sw_state_t;

	typedef struct packed {
		logic [7:0]           coarse;
		logic [tap_width-1:0] tap;
	} phase_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ahb_req_t;

endpackage : pll_ctrl_pkg

/* File: design/pll_clock_switchover_phase_step.sv */
// Purpose: reference clock switchover and dynamic phase stepping control for a pll
// Assumes: reference and phase-step clocks are pins, sampled by core_clk_in, far slower than it
// Notes:   zero wait state ahb-lite slave; one level interrupt output
//
// How it works
// R1: a reference with no edge for two of its measured periods raises its lost flag.
// R2: when the selected primary stops toggling and auto mode is on, the state machine moves the select to the secondary.
// R3: a rising transition of the manual switch request starts the switchover sequence.
// R4: user logic holds the switch request high for at least three of the longer reference periods.
// R5: in a switchover the counter reference gate closes on a falling edge of the selected reference.
// R6: on the next falling edge of the other reference the multiplexer changes over.
// R7: the active reference indicator follows the multiplexer at that change.
// R8: each step waits on the falling edge of whichever reference still toggles, so a dead input never stalls it.
// R9: the manual request still works as an override while auto switchover is enabled.
// R10: each phase step completes within one phase-step clock cycle.
// R11: phase steps move among the oscillator taps, carry into the coarse count at a tap wrap, and may be repeated without limit.
// R12: there are eight taps, and an output on tap n lags by n fine steps.
// R13: coarse shifts in whole oscillator periods come from the counter start value and add to the fine tap.
// R14: the secondary has its own lost flag and the machine can return to the primary once it toggles again.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
module pll_clock_switchover_phase_step (
	input  wire logic                     core_clk_in,
	input  wire logic                     rst_in,
	input  wire logic                     primary_ref_clock_in,
	input  wire logic                     secondary_ref_clock_in,
	input  wire logic                     switch_request_in,
	input  wire logic                     phase_step_clock_in,
	input  wire logic                     phase_step_in,
	input  wire logic                     phase_up_in,
	input  wire logic                     phase_output_sel_in,
	input  wire logic                     hsel_in,
	input  wire logic [31:0]              haddr_in,
	input  wire logic [1:0]               htrans_in,
	input  wire logic                     hwrite_in,
	input  wire logic [2:0]               hsize_in,
	input  wire logic [31:0]              hwdata_in,
	input  wire logic                     hready_in,
	output logic      [31:0]              hrdata_out,
	output logic                          hreadyout_out,
	output logic                          hresp_out,
	output logic                          ref_select_out,
	output logic                          ref_gate_out,
	output logic                          active_ref_out,
	output logic                          primary_clock_lost_out,
	output logic                          secondary_clock_lost_out,
	output logic                          phase_done_out,
	output pll_ctrl_pkg::phase_t          phase0_out,
	output pll_ctrl_pkg::phase_t          phase1_out,
	output logic                          irq_out
);
	import pll_ctrl_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------------------------
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] sync_prev;
	logic [1:0] ref_fall;
	logic [1:0] ref_rise;
	logic       scan_rise;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sync_a    <= 3'h0;
			sync_b    <= 3'h0;
			sync_prev <= 3'h0;
		end else begin
			sync_a    <= {phase_step_clock_in, secondary_ref_clock_in, primary_ref_clock_in};
			sync_b    <= sync_a;
			sync_prev <= sync_b;
		end
	end

	assign ref_fall  = sync_prev[1:0] & ~sync_b[1:0];
	assign ref_rise  = ~sync_prev[1:0] & sync_b[1:0];
	assign scan_rise = ~sync_prev[2] & sync_b[2];

	// ---------------------------------------------------------------
	// clock sense: period measure and loss detection
	// ---------------------------------------------------------------
	logic [cnt_width-1:0] idle_cnt [2];
	logic [cnt_width-1:0] period   [2];
	logic [1:0]           lost;
	logic [cnt_width-1:0] next_idle_cnt [2];
	logic [cnt_width-1:0] next_period   [2];
	logic [1:0]           next_lost;

	function automatic logic [cnt_width:0] lost_limit(input logic [cnt_width-1:0] p);
		lost_limit = (cnt_width+1)'(p) * (cnt_width+1)'(lost_periods);
	endfunction : lost_limit

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_idle_cnt[i] = (idle_cnt[i] == cnt_max) ? idle_cnt[i] : idle_cnt[i] + 16'h0001;
			next_period[i]   = period[i];
			next_lost[i]     = lost[i];
			if (ref_rise[i]) begin
				next_idle_cnt[i] = 16'h0000;
				next_period[i]   = idle_cnt[i] + 16'h0001;
				next_lost[i]     = 1'b0;                                         // R14
			end else if ({1'b0, idle_cnt[i]} > lost_limit(period[i])) begin
				next_lost[i]     = 1'b1;                                         // R1 R14
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < 2; i++) begin
				idle_cnt[i] <= 16'h0000;
				period[i]   <= period_init;
			end
			lost <= 2'h0;
		end else begin
			idle_cnt <= next_idle_cnt;
			period   <= next_period;
			lost     <= next_lost;
		end
	end

	assign primary_clock_lost_out   = lost[0];
	assign secondary_clock_lost_out = lost[1];

	// ---------------------------------------------------------------
	// switchover state machine
	// ---------------------------------------------------------------
	sw_state_t state;
	sw_state_t next_state;
	logic      sel;
	logic      gate;
	logic      req_prev;
	logic      next_sel;
	logic      next_gate;
	logic      manual_rise;
	logic      auto_start;
	logic      gate_edge;
	logic      swap_edge;
	logic      switch_done;
	logic [1:0] ctrl;

	// the soft request bit is ored in so software can also override
	assign manual_rise = (switch_request_in | ctrl[ctrl_swreq_bit]) & ~req_prev;  // R3 R9
	assign auto_start  = ctrl[ctrl_auto_bit] & lost[sel] & ~lost[~sel];         // R2 R14
	// a dead reference would never give an edge, so follow the live one
	assign gate_edge   = lost[sel] ? ref_fall[~sel] : ref_fall[sel];            // R5 R8
	assign swap_edge   = lost[~sel] ? ref_fall[sel] : ref_fall[~sel];           // R6 R8

	always_comb begin
		next_state  = state;
		next_sel    = sel;
		next_gate   = gate;
		switch_done = 1'b0;
		case (state)
			sw_idle: begin
				if (manual_rise || auto_start) begin
					next_state = sw_gate;                                      // R2 R3 R9
				end
			end
			sw_gate: begin
				if (gate_edge) begin
					next_gate  = 1'b0;                                         // R5
					next_state = sw_swap;
				end
			end
			sw_swap: begin
				if (swap_edge) begin
					next_sel    = ~sel;                                        // R6 R7
					next_gate   = 1'b1;
					switch_done = 1'b1;
					next_state  = sw_idle;
				end
			end
			default: begin
				next_state = sw_idle;
				next_gate  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state    <= sw_idle;
			sel      <= 1'b0;
			gate     <= 1'b1;
			req_prev <= 1'b0;
		end else begin
			state    <= next_state;
			sel      <= next_sel;
			gate     <= next_gate;
			req_prev <= switch_request_in | ctrl[ctrl_swreq_bit];
		end
	end

	assign ref_select_out = sel;
	assign ref_gate_out   = gate;
	assign active_ref_out = sel;                                                // R7

	// ---------------------------------------------------------------
	// dynamic phase stepping
	// ---------------------------------------------------------------
	phase_t phase      [num_outputs];
	phase_t next_phase [num_outputs];
	logic   step_now;
	logic   done;
	logic   coarse_wr  [num_outputs];
	logic [7:0] coarse_wdata;

	function automatic phase_t step_tap(input phase_t p, input logic up);
		step_tap = p;
		if (up) begin
			step_tap.tap = p.tap + 3'h1;
			if (p.tap == tap_last) step_tap.coarse = p.coarse + 8'h01;          // R13
		end else begin
			step_tap.tap = p.tap - 3'h1;
			if (p.tap == 3'h0) step_tap.coarse = p.coarse - 8'h01;              // R13
		end
	endfunction : step_tap

	assign step_now = scan_rise & phase_step_in;                                // R10

	always_comb begin
		for (int i = 0; i < num_outputs; i++) begin
			next_phase[i] = phase[i];
			if (coarse_wr[i]) begin
				next_phase[i].coarse = coarse_wdata;                            // R13
			end else if (step_now && (int'(phase_output_sel_in) == i)) begin
				next_phase[i] = step_tap(phase[i], phase_up_in);                // R11 R12
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < num_outputs; i++) begin
				phase[i] <= '{coarse: coarse_reset, tap: 3'h0};
			end
			done <= 1'b0;
		end else begin
			phase <= next_phase;
			done  <= step_now;                                                  // R10
		end
	end

	assign phase_done_out = done;
	assign phase0_out     = phase[0];
	assign phase1_out     = phase[1];

	// ---------------------------------------------------------------
	// ahb-lite slave and interrupts
	// ---------------------------------------------------------------
	ahb_req_t              req;
	ahb_req_t              next_req;
	logic [1:0]            next_ctrl;
	logic [irq_width-1:0]  irq_status;
	logic [irq_width-1:0]  irq_mask;
	logic [irq_width-1:0]  next_irq_status;
	logic [irq_width-1:0]  next_irq_mask;
	logic [irq_width-1:0]  irq_events;
	logic [1:0]            lost_rise;
	logic [31:0]           rdata;
	logic [31:0]           next_rdata;

	function automatic logic [31:0] phase_word(input phase_t p);
		phase_word = {16'h0000, p.coarse, 5'h00, p.tap};
	endfunction : phase_word

	assign lost_rise  = next_lost & ~lost;
	assign irq_events = {done, switch_done, lost_rise[1], lost_rise[0]};
	assign coarse_wdata = hwdata_in[coarse_lsb +: 8];

	always_comb begin
		next_req        = '{valid: hsel_in & hready_in & htrans_in[1], write: hwrite_in, addr: haddr_in[7:0]};
		next_ctrl       = ctrl;
		next_irq_mask   = irq_mask;
		next_irq_status = irq_status;
		next_rdata      = 32'h0000_0000;
		coarse_wr[0]    = 1'b0;
		coarse_wr[1]    = 1'b0;
		// the soft request is self clearing so one write gives one edge
		next_ctrl[ctrl_swreq_bit] = 1'b0;
		if (req.valid && req.write) begin
			case (req.addr)
				ctrl_off:     next_ctrl     = hwdata_in[1:0];
				irq_mask_off: next_irq_mask = hwdata_in[irq_width-1:0];
				phase0_off:   coarse_wr[0]  = 1'b1;
				phase1_off:   coarse_wr[1]  = 1'b1;
				default:      next_ctrl     = next_ctrl;
			endcase
		end
		if (next_req.valid && !next_req.write) begin
			case (next_req.addr)
				ctrl_off:       next_rdata = {30'h0, ctrl};
				status_off:     next_rdata = {26'h0, state, lost, gate, sel};
				irq_status_off: next_rdata = {28'h0, irq_status};
				irq_mask_off:   next_rdata = {28'h0, irq_mask};
				phase0_off:     next_rdata = phase_word(phase[0]);
				phase1_off:     next_rdata = phase_word(phase[1]);
				default:        next_rdata = 32'h0000_0000;
			endcase
			if (next_req.addr == irq_status_off) next_irq_status = '0;
		end
		// a new event in the clearing cycle survives
		next_irq_status = next_irq_status | irq_events;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			req        <= '{valid: 1'b0, write: 1'b0, addr: 8'h00};
			ctrl       <= ctrl_reset;
			irq_status <= '0;
			irq_mask   <= irq_mask_reset;
			rdata      <= 32'h0000_0000;
		end else begin
			req        <= next_req;
			ctrl       <= next_ctrl;
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			rdata      <= next_rdata;
		end
	end

	assign hrdata_out    = rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign irq_out       = |(irq_status & irq_mask);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence gate_closes_s;
		(state == sw_gate) && gate_edge ##1 !gate && (state == sw_swap);
	endsequence

	sequence swap_done_s;
		(state == sw_swap) && swap_edge ##1 gate && (state == sw_idle);
	endsequence

	lost_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
		!ref_rise[0] && ({1'b0, idle_cnt[0]} > lost_limit(period[0])) |=> primary_clock_lost_out)
		else $error("primary lost flag not raised");
	secondary_lost_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R14
		ref_rise[1] |=> !secondary_clock_lost_out)
		else $error("secondary lost flag not cleared by an edge");
	auto_switch_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R2
		(state == sw_idle) && auto_start |=> (state == sw_gate))
		else $error("automatic switchover not started");
	manual_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R3
		(state == sw_idle) && $rose(switch_request_in) && !ctrl[ctrl_swreq_bit] && !req_prev |=> (state == sw_gate))
		else $error("manual request did not start switchover");
	gate_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R5
		(state == sw_gate) && !lost[sel] && ref_fall[sel] |-> gate_closes_s)
		else $error("reference gate not closed on selected falling edge");
	swap_mux_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R6
		(state == sw_swap) && !lost[~sel] && ref_fall[~sel] |-> swap_done_s ##0 (sel != $past(sel)))
		else $error("multiplexer did not change over");
	active_ind_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R7
		$changed(active_ref_out) |-> $past(state) == sw_swap)
		else $error("active indicator moved outside a changeover");
	dead_input_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R8
		(state == sw_gate) && lost[sel] && ref_fall[~sel] |=> !gate)
		else $error("switchover blocked by dead input");
	override_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R9
		(state == sw_idle) && ctrl[ctrl_auto_bit] && manual_rise |=> (state == sw_gate))
		else $error("manual override ignored in auto mode");
	step_time_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10
		step_now |=> phase_done_out)
		else $error("phase step not done in one step clock");
	tap_wrap_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R11 R12 R13
		step_now && phase_up_in && !phase_output_sel_in && (phase[0].tap == tap_last) && !coarse_wr[0]
		|=> (phase[0].tap == 3'h0) && (phase[0].coarse == $past(phase[0].coarse) + 8'h01))
		else $error("tap wrap did not carry into coarse");

endmodule : pll_clock_switchover_phase_step

/* File: verification/tb_top.sv */
// Purpose: self-checking bench for the reference switchover and phase step block
// Assumes: zero wait state register slave, references far slower than the core clock
// Notes:   drivers note expected results in queues; one monitor pops and compares them
`timescale 1ns/10ps
module tb_top;
	import pll_ctrl_pkg::*;
	logic        core_clk_in, rst_in, hsel, hwrite, rd_pend, seen, prim_run, sec_run;
	logic        prim_ref, sec_ref, sw_req, step_clk, step_en, step_up, step_sel;
	logic        hreadyout_out, hresp_out, ref_select_out, ref_gate_out, active_ref_out;
	logic        primary_clock_lost_out, secondary_clock_lost_out, phase_done_out, irq_out;
	logic [31:0] haddr, hwdata, hrdata_out, rnd;
	logic [1:0]  htrans;
	logic [2:0]  hsize, prev_trio, trio;
	phase_t      phase0_out, phase1_out;
	logic [10:0] m_ph [2];
	logic [31:0] rd_q [$];
	logic [21:0] ph_q [$];
	logic [2:0]  sw_q [$];
	int          mismatches, comparisons, cycles, i, n;

	pll_clock_switchover_phase_step u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.primary_ref_clock_in(prim_ref), .secondary_ref_clock_in(sec_ref), .switch_request_in(sw_req),
		.phase_step_clock_in(step_clk), .phase_step_in(step_en), .phase_up_in(step_up),
		.phase_output_sel_in(step_sel), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout_out),
		.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
		.ref_select_out(ref_select_out), .ref_gate_out(ref_gate_out), .active_ref_out(active_ref_out),
		.primary_clock_lost_out(primary_clock_lost_out), .secondary_clock_lost_out(secondary_clock_lost_out),
		.phase_done_out(phase_done_out), .phase0_out(phase0_out), .phase1_out(phase1_out), .irq_out(irq_out));

	user_logic_model u_user (.core_clk_in(core_clk_in), .primary_run_in(prim_run), .secondary_run_in(sec_run),
		.phase_done_in(phase_done_out), .primary_ref_clock_out(prim_ref), .secondary_ref_clock_out(sec_ref),
		.switch_request_out(sw_req), .phase_step_clock_out(step_clk), .phase_step_out(step_en),
		.phase_up_out(step_up), .phase_output_sel_out(step_sel));

	always #5 core_clk_in = ~core_clk_in;

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// entered right after a rising edge; ends at the edge that closes the data phase
	task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, input logic [31:0] exp);
		int k;
		logic [31:0] r;
		// only the low address byte is decoded; the rest and idle write data carry noise
		r = $urandom;
		hsel <= 1'b1;
		haddr <= {r[31:8], addr};
		hwrite <= wr;
		htrans <= 2'h2;
		if (!wr) rd_q.push_back(exp);
		@(posedge core_clk_in);
		for (k = 0; k < 50 && hreadyout_out !== 1'b1; k++) @(posedge core_clk_in);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? wdata : r;
		@(posedge core_clk_in);
		for (k = 0; k < 50 && hreadyout_out !== 1'b1; k++) @(posedge core_clk_in);
	endtask : ahb

	// ---------------------------------------------------------------
	// monitor and timeout
	// ---------------------------------------------------------------
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
		trio = {ref_select_out, active_ref_out, ref_gate_out};
		if (rst_in) begin
			rd_pend = 1'b0;
			prev_trio = 3'b001;
		end else begin
			if (rd_pend) chk(hrdata_out, (rd_q.size() > 0) ? rd_q.pop_front() : 32'hDEAD0000, "read data");
			if (phase_done_out === 1'b1)
				chk(32'({phase0_out, phase1_out}), 32'((ph_q.size() > 0) ? ph_q.pop_front() : 22'h3FFFFF), "phase");
			if (trio !== prev_trio)
				chk(32'(trio), 32'((sw_q.size() > 0) ? sw_q.pop_front() : 3'h7 ^ trio), "select gate active");
			prev_trio = trio;
			rd_pend = hsel && hreadyout_out && htrans[1] && !hwrite;
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		core_clk_in = 1'b0;
		rst_in = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		prim_run = 1'b1;
		sec_run = 1'b1;
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		m_ph[0] = 11'h008;
		m_ph[1] = 11'h008;
		void'($urandom(32'h4A43));
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		chk(32'({ref_select_out, active_ref_out, ref_gate_out, hresp_out, irq_out}), 32'h04, "after reset");
		ahb(0, ctrl_off, 0, 32'h00000001);
		ahb(0, status_off, 0, 32'h00000002);
		ahb(0, irq_mask_off, 0, 32'h00000000);
		ahb(0, phase0_off, 0, 32'h00000100);
		ahb(0, phase1_off, 0, 32'h00000100);
		ahb(1, 8'h20, 32'hFFFFFFFF, 0);
		ahb(0, 8'h20, 0, 32'h00000000);
		// manual request while automatic switchover is enabled
		sw_q.push_back(3'b000);
		sw_q.push_back(3'b111);
		u_user.request_switch();
		for (i = 0; i < 300 && active_ref_out !== 1'b1; i++) @(posedge core_clk_in);
		chk(32'(active_ref_out), 1, "manual switch");
		chk(32'(irq_out), 0, "masked interrupt");
		ahb(1, irq_mask_off, 32'h0000000F, 0);
		@(posedge core_clk_in);
		chk(32'(irq_out), 1, "interrupt raised");
		ahb(0, irq_status_off, 0, 32'h00000004);
		repeat (2) @(posedge core_clk_in);
		chk(32'(irq_out), 0, "interrupt cleared");
		// software request back to the primary
		sw_q.push_back(3'b110);
		sw_q.push_back(3'b001);
		ahb(1, ctrl_off, 32'h00000003, 0);
		for (i = 0; i < 300 && active_ref_out !== 1'b0; i++) @(posedge core_clk_in);
		ahb(0, irq_status_off, 0, 32'h00000004);
		ahb(0, ctrl_off, 0, 32'h00000001);
		// primary dies: loss flag then automatic switch
		sw_q.push_back(3'b000);
		sw_q.push_back(3'b111);
		prim_run <= 1'b0;
		for (i = 0; i < 300 && primary_clock_lost_out !== 1'b1; i++) @(posedge core_clk_in);
		chk(32'(primary_clock_lost_out), 1, "primary lost");
		for (i = 0; i < 300 && active_ref_out !== 1'b1; i++) @(posedge core_clk_in);
		chk(32'(active_ref_out), 1, "automatic switch");
		ahb(0, status_off, 0, 32'h00000007);
		ahb(0, irq_status_off, 0, 32'h00000005);
		// primary returns, secondary dies: automatic return
		prim_run <= 1'b1;
		for (i = 0; i < 300 && primary_clock_lost_out !== 1'b0; i++) @(posedge core_clk_in);
		sw_q.push_back(3'b110);
		sw_q.push_back(3'b001);
		sec_run <= 1'b0;
		for (i = 0; i < 300 && active_ref_out !== 1'b0; i++) @(posedge core_clk_in);
		chk(32'({secondary_clock_lost_out, primary_clock_lost_out, active_ref_out}), 32'h4, "return");
		ahb(0, status_off, 0, 32'h0000000A);
		ahb(0, irq_status_off, 0, 32'h00000006);
		sec_run <= 1'b1;
		for (i = 0; i < 300 && secondary_clock_lost_out !== 1'b0; i++) @(posedge core_clk_in);
		// phase steps: first ten cross the tap wrap on output zero
		for (n = 0; n < 25; n++) begin
			rnd = $urandom;
			if (n < 10) rnd[1:0] = 2'b10;
			m_ph[rnd[0]] = rnd[1] ? m_ph[rnd[0]] + 11'h001 : m_ph[rnd[0]] - 11'h001;
			ph_q.push_back({m_ph[0], m_ph[1]});
			u_user.step(rnd[0], rnd[1], seen);
			chk(32'(seen), 1, "step within one step clock cycle");
		end
		ahb(1, phase1_off, 32'h00000500, 0);
		m_ph[1] = {8'h05, m_ph[1][2:0]};
		ahb(0, phase1_off, 0, {16'h0000, m_ph[1][10:3], 5'h00, m_ph[1][2:0]});
		ahb(0, phase0_off, 0, {16'h0000, m_ph[0][10:3], 5'h00, m_ph[0][2:0]});
		ahb(0, irq_status_off, 0, 32'h00000008);
		chk(32'(irq_out), 0, "step interrupt cleared");
		m_ph[1] = m_ph[1] + 11'h001;
		ph_q.push_back({m_ph[0], m_ph[1]});
		u_user.step(1'b1, 1'b1, seen);
		chk(32'(irq_out), 1, "step interrupt");
		@(posedge core_clk_in);
		ahb(0, irq_status_off, 0, 32'h00000008);
		repeat (2) @(posedge core_clk_in);
		chk(32'(rd_q.size() + ph_q.size() + sw_q.size()), 0, "notes left");
		conclude();
	end
endmodule : tb_top

/* File: verification/user_logic_model.sv */
// Purpose: behavioural user logic and the two reference oscillators around the switchover block
// Assumes: reference half periods far above four core cycles
// Notes:   a stopped reference is held low, as a dead oscillator input would be
`timescale 1ns/10ps
module user_logic_model #(
	parameter int prim_half_ns = 80,
	parameter int sec_half_ns  = 100
) (
	input  wire logic core_clk_in,
	input  wire logic primary_run_in,
	input  wire logic secondary_run_in,
	input  wire logic phase_done_in,
	output logic      primary_ref_clock_out,
	output logic      secondary_ref_clock_out,
	output logic      switch_request_out,
	output logic      phase_step_clock_out,
	output logic      phase_step_out,
	output logic      phase_up_out,
	output logic      phase_output_sel_out
);
	initial begin
		primary_ref_clock_out = 1'b0;
		secondary_ref_clock_out = 1'b0;
		switch_request_out = 1'b0;
		phase_step_clock_out = 1'b0;
		phase_step_out = 1'b0;
		phase_up_out = 1'b0;
		phase_output_sel_out = 1'b0;
	end

	// ---------------------------------------------------------------
	// reference oscillators
	// ---------------------------------------------------------------
	always begin
		#(prim_half_ns);
		primary_ref_clock_out = primary_run_in ? ~primary_ref_clock_out : 1'b0;
	end

	always begin
		#(sec_half_ns);
		secondary_ref_clock_out = secondary_run_in ? ~secondary_ref_clock_out : 1'b0;
	end

	// ---------------------------------------------------------------
	// user requests
	// ---------------------------------------------------------------
	// held three of the longer reference periods plus margin
	task automatic request_switch();
		@(posedge core_clk_in);
		switch_request_out <= 1'b1;
		repeat (6 * sec_half_ns / 10 + 4) @(posedge core_clk_in);
		switch_request_out <= 1'b0;
	endtask : request_switch

	// one step clock cycle; reports whether the done pulse came while the step clock was high
	task automatic step(input logic sel, input logic up, output logic seen);
		int i;
		@(posedge core_clk_in);
		phase_output_sel_out <= sel;
		phase_up_out <= up;
		phase_step_out <= 1'b1;
		@(posedge core_clk_in);
		phase_step_clock_out <= 1'b1;
		seen = 1'b0;
		for (i = 0; i < 16; i++) begin
			@(posedge core_clk_in);
			if (phase_done_in === 1'b1) seen = 1'b1;
		end
		phase_step_clock_out <= 1'b0;
		phase_step_out <= 1'b0;
		repeat (8) @(posedge core_clk_in);
	endtask : step
endmodule : user_logic_model
